// >>> dead_time_gen.sv
// dead time insertion for one true/inverted output pair
`timescale 1ns/100ps
`default_nettype none
module dead_time_gen
  import timer1_cmp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // prescaled timer tick
  input wire logic tick,
  // waveform and delays
  input wire logic wave,
  input wire logic [3:0] delay_true,
  input wire logic [3:0] delay_inv,
  // delayed outputs
  output logic out_true,
  output logic out_inv
);
  typedef struct packed {
    logic level;
    logic [3:0] count;
    logic out_true;
    logic out_inv;
  } dt_state_type;

  dt_state_type state;
  dt_state_type next_state;

  // falling edges pass at once, rising edges wait out the delay
  always_comb begin
    next_state = state;
    if (wave != state.level) begin
      next_state.level = wave;
      next_state.out_true = 1'b0;
      next_state.out_inv = 1'b0;
      next_state.count = wave ? delay_true : delay_inv;
    end else if (state.count != 4'h0) begin
      if (tick) begin
        next_state.count = state.count - 4'h1;
      end
    end else begin
      next_state.out_true = state.level;
      next_state.out_inv = ~state.level;
    end
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign out_true = state.out_true;
  assign out_inv = state.out_inv;
endmodule : dead_time_gen
`default_nettype wire

// >>> timer1_cmp_pkg.sv
// constants shared by the timer compare and flag section
package timer1_cmp_pkg;
  // i/o register addresses
  localparam logic [5:0] ADDR_DEAD_TIME = 6'h24;
  localparam logic [5:0] ADDR_CMP_B = 6'h2C;
  localparam logic [5:0] ADDR_FLAGS = 6'h38;
  localparam logic [5:0] ADDR_ENABLES = 6'h39;
  localparam logic [5:0] ADDR_CMP_A = 6'h30;
  localparam logic [5:0] ADDR_TOP = 6'h31;
  localparam logic [5:0] ADDR_CMP_D = 6'h32;
  localparam logic [5:0] ADDR_HIGH_BYTE = 6'h33;
  // bit positions shared by flag and enable registers
  localparam int BIT_D = 7;
  localparam int BIT_A = 6;
  localparam int BIT_B = 5;
  localparam int BIT_WRAP = 2;
  localparam logic [7:0] OWN_BITS_MASK = 8'hE4;
  // dead time fields
  localparam int DT_TRUE_MSB = 7;
  localparam int DT_TRUE_LSB = 4;
  localparam int DT_INV_MSB = 3;
  localparam int DT_INV_LSB = 0;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESET_CMP = 10'h000;
  localparam logic [9:0] RESET_TOP = 10'h0FF;
  // smallest legal top value
  localparam logic [9:0] TOP_MIN = 10'h003;
  // interrupt vector numbers
  localparam logic [5:0] VEC_MATCH_A = 6'h03;
  localparam logic [5:0] VEC_WRAP = 6'h04;
  localparam logic [5:0] VEC_MATCH_B = 6'h09;
  localparam logic [5:0] VEC_MATCH_D = 6'h10;
  // waveform generation modes when pwm is on
  localparam logic [1:0] MODE_FAST = 2'h0;
  localparam logic [1:0] MODE_DUAL = 2'h1;
  localparam logic [1:0] MODE_PWM6_SINGLE = 2'h2;
  localparam logic [1:0] MODE_PWM6_DUAL = 2'h3;
  // number of dead time channels (a, b, d)
  localparam int CHANNELS = 3;
endpackage : timer1_cmp_pkg

// >>> timer1_compare.sv
// compare channels, flags, interrupt enables and dead time of timer one
`timescale 1ns/100ps
`default_nettype none
module timer1_compare
  import timer1_cmp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // cpu i/o bus
  input wire logic [5:0] io_addr,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // processor interrupt side
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic [5:0] vector_id,
  // counter side
  input wire logic [9:0] counter_value,
  input wire logic count_step,
  input wire logic count_down,
  input wire logic pwm_enable,
  input wire logic [1:0] mode_select,
  input wire logic prescale_tick,
  // waveforms before dead time, index 0 a, 1 b, 2 d
  input wire logic [2:0] waveform_in,
  // counter control
  output logic counter_clear,
  // interrupt requests
  output logic irq_match_a,
  output logic irq_match_b,
  output logic irq_match_d,
  output logic irq_wrap,
  // outputs after dead time
  output logic [2:0] waveform_output,
  output logic [2:0] waveform_output_n
);
  typedef struct packed {
    logic [9:0] compare_value_a;
    logic [9:0] compare_value_b;
    logic [9:0] top_value;
    logic [9:0] compare_value_d;
    logic [1:0] shared_high_byte;
    logic [7:0] dead_time_value;
    logic [7:0] timer_irq_enables;
    logic [7:0] timer_event_flags;
    logic [7:0] hit_delay;
    logic [7:0] clear_pending;
    logic [7:0] rdata;
    logic clear_counter;
  } cmp_state_type;

  cmp_state_type state;
  cmp_state_type next_state;
  logic [7:0] hit_now;
  logic [7:0] vector_clear;
  logic top_hit;
  logic dual_slope;
  logic [3:0] dead_time_true_out;
  logic [3:0] dead_time_inverted_out;

  // 10-bit value from the shared high byte and a bus byte
  function automatic logic [9:0] join_word(input logic [1:0] hi,
                                            input logic [7:0] lo);
    join_word = {hi, lo};
  endfunction : join_word

  // one-hot position of a flag in the flag layout
  function automatic logic [7:0] flag_bit(input int pos);
    flag_bit = 8'h01 << pos;
  endfunction : flag_bit

  assign dual_slope = pwm_enable &&
    (mode_select == MODE_DUAL || mode_select == MODE_PWM6_DUAL);

  assign top_hit = count_step && !count_down &&
    counter_value == state.top_value;

  // match detection for channels a, b and d on a counting step
  always_comb begin
    hit_now = 8'h00;
    if (count_step) begin
      if (counter_value == state.compare_value_a) begin
        hit_now = hit_now | flag_bit(BIT_A);
      end
      if (counter_value == state.compare_value_b) begin
        hit_now = hit_now | flag_bit(BIT_B);
      end
      if (counter_value == state.compare_value_d) begin
        hit_now = hit_now | flag_bit(BIT_D);
      end
    end
  end

  // vector acknowledge decode
  always_comb begin
    vector_clear = 8'h00;
    if (vector_taken) begin
      unique case (vector_id)
        VEC_MATCH_A: vector_clear = flag_bit(BIT_A);
        VEC_MATCH_B: vector_clear = flag_bit(BIT_B);
        VEC_MATCH_D: vector_clear = flag_bit(BIT_D);
        VEC_WRAP: vector_clear = flag_bit(BIT_WRAP);
        default: vector_clear = 8'h00;
      endcase
    end
  end

  // next state: bus writes, reads, flag set and clear
  always_comb begin
    logic [7:0] set_now;
    logic [9:0] word;
    set_now = 8'h00;
    word = join_word(state.shared_high_byte, io_wdata);
    next_state = state;

    next_state.hit_delay = hit_now;
    set_now = state.hit_delay;
    if (top_hit && !dual_slope) begin
      set_now = set_now | flag_bit(BIT_WRAP);
    end
    if (dual_slope && count_step && count_down &&
        counter_value == RESET_CMP) begin
      set_now = set_now | flag_bit(BIT_WRAP);
    end
    next_state.clear_counter = top_hit && !dual_slope;

    next_state.timer_event_flags =
      ((state.timer_event_flags & ~state.clear_pending & ~vector_clear)
       | set_now) & OWN_BITS_MASK;
    next_state.clear_pending = 8'h00;

    if (io_write) begin
      unique case (io_addr)
        ADDR_CMP_A: next_state.compare_value_a = word;
        ADDR_CMP_B: next_state.compare_value_b = word;
        ADDR_CMP_D: next_state.compare_value_d = word;
        ADDR_TOP: begin
          next_state.top_value = (word < TOP_MIN) ? TOP_MIN : word;
        end
        ADDR_HIGH_BYTE: next_state.shared_high_byte = io_wdata[1:0];
        ADDR_DEAD_TIME: next_state.dead_time_value = io_wdata;
        ADDR_ENABLES: next_state.timer_irq_enables =
          io_wdata & OWN_BITS_MASK;
        ADDR_FLAGS: next_state.clear_pending = io_wdata & OWN_BITS_MASK;
        default: next_state.clear_pending = 8'h00;
      endcase
    end

    // read data; reading a compare loads its high bits
    if (io_read) begin
      unique case (io_addr)
        ADDR_CMP_A: begin
          next_state.rdata = state.compare_value_a[7:0];
          next_state.shared_high_byte = state.compare_value_a[9:8];
        end
        ADDR_CMP_B: begin
          next_state.rdata = state.compare_value_b[7:0];
          next_state.shared_high_byte = state.compare_value_b[9:8];
        end
        ADDR_CMP_D: begin
          next_state.rdata = state.compare_value_d[7:0];
          next_state.shared_high_byte = state.compare_value_d[9:8];
        end
        ADDR_TOP: begin
          next_state.rdata = state.top_value[7:0];
          next_state.shared_high_byte = state.top_value[9:8];
        end
        ADDR_HIGH_BYTE: next_state.rdata = {6'h00, state.shared_high_byte};
        ADDR_DEAD_TIME: next_state.rdata = state.dead_time_value;
        ADDR_ENABLES: next_state.rdata = state.timer_irq_enables;
        ADDR_FLAGS: next_state.rdata = state.timer_event_flags;
        default: next_state.rdata = RESET_BYTE;
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= '0;
      state.top_value <= RESET_TOP;
      state.compare_value_a <= RESET_CMP;
      state.compare_value_b <= RESET_CMP;
      state.compare_value_d <= RESET_CMP;
    end else begin
      state <= next_state;
    end
  end

  assign io_rdata = state.rdata;
  assign counter_clear = state.clear_counter;

  assign irq_match_a = global_irq_enable &&
    state.timer_irq_enables[BIT_A] && state.timer_event_flags[BIT_A];
  assign irq_match_b = global_irq_enable &&
    state.timer_irq_enables[BIT_B] && state.timer_event_flags[BIT_B];
  assign irq_match_d = global_irq_enable &&
    state.timer_irq_enables[BIT_D] && state.timer_event_flags[BIT_D];
  assign irq_wrap = global_irq_enable &&
    state.timer_irq_enables[BIT_WRAP] && state.timer_event_flags[BIT_WRAP];

  assign dead_time_true_out =
    state.dead_time_value[DT_TRUE_MSB:DT_TRUE_LSB];
  assign dead_time_inverted_out =
    state.dead_time_value[DT_INV_MSB:DT_INV_LSB];

  // one dead time pair per channel, all sharing the same delays
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_dead
      dead_time_gen u_dead (
        .mclk(mclk),
        .rst(rst),
        .tick(prescale_tick),
        .wave(waveform_in[ch]),
        .delay_true(dead_time_true_out),
        .delay_inv(dead_time_inverted_out),
        .out_true(waveform_output[ch]),
        .out_inv(waveform_output_n[ch])
      );
    end
  endgenerate
endmodule : timer1_compare
`default_nettype wire

// >>> timer1_compare_monitor.sv
// assertion checker for the timer compare and flag section
`timescale 1ns/100ps
`default_nettype none
module timer1_compare_monitor
  import timer1_cmp_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus and processor side
  input wire logic [5:0] io_addr,
  input wire logic io_write,
  input wire logic io_read,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic global_irq_enable,
  input wire logic vector_taken,
  input wire logic [5:0] vector_id,
  // counter side
  input wire logic count_step,
  input wire logic count_down,
  input wire logic [2:0] waveform_in,
  // watched outputs
  input wire logic counter_clear,
  input wire logic irq_match_a,
  input wire logic irq_match_b,
  input wire logic irq_match_d,
  input wire logic irq_wrap,
  input wire logic [2:0] waveform_output,
  input wire logic [2:0] waveform_output_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // zero write to the flags while d is pending
  sequence s_zero_write;
    io_write && io_addr == ADDR_FLAGS && io_wdata == 8'h00
      && irq_match_d && !vector_taken;
  endsequence
  // nothing else may disturb the flag meanwhile
  sequence s_quiet;
    !vector_taken && !io_write && global_irq_enable;
  endsequence
  AST_IRQ_GATE:
    assert property (!global_irq_enable |-> !irq_match_a && !irq_match_b
      && !irq_match_d && !irq_wrap) else $error("irq without global enable");
  AST_CLEAR_CAUSE:
    assert property (counter_clear |-> $past(count_step) && !$past(count_down))
      else $error("counter clear without upward step");
  AST_MATCH_STEP:
    assert property ($rose(irq_match_a) && $stable(global_irq_enable)
      && !$past(io_write) |-> $past(count_step, 2))
      else $error("match flag without counting");
  AST_WRAP_STEP:
    assert property ($rose(irq_wrap) && $stable(global_irq_enable)
      && !$past(io_write) |-> $past(count_step))
      else $error("wrap flag late or without step");
  AST_VECTOR_CLEAR:
    assert property (vector_taken && vector_id == VEC_MATCH_A
      && !$past(count_step) |=> !irq_match_a)
      else $error("vector did not clear flag");
  AST_ONE_CLEAR:
    assert property (io_write && io_addr == ADDR_FLAGS && io_wdata[BIT_A]
      && !count_step |-> ##2 !irq_match_a) else $error("write one kept flag");
  AST_ZERO_KEEP:
    assert property (s_zero_write ##1 s_quiet ##1 global_irq_enable
      |-> irq_match_d) else $error("write zero cleared flag");
  AST_RDATA_HOLD:
    assert property (!$past(io_read) |-> $stable(io_rdata))
      else $error("read data moved without read");
  AST_DT_BREAK:
    assert property ($changed(waveform_in[0]) |-> ##[1:2]
      (!waveform_output[0] && !waveform_output_n[0]))
      else $error("no gap on waveform change");
endmodule : timer1_compare_monitor
bind timer1_compare timer1_compare_monitor mon (.mclk, .rst, .io_addr,
  .io_write, .io_read, .io_wdata, .io_rdata, .global_irq_enable,
  .vector_taken, .vector_id, .count_step, .count_down, .waveform_in,
  .counter_clear, .irq_match_a, .irq_match_b, .irq_match_d, .irq_wrap,
  .waveform_output, .waveform_output_n);
`default_nettype wire

// >>> timer1_compare_test.sv
// self-checking bench for the timer compare and flag section
`timescale 1ns/100ps
`default_nettype none
module timer1_compare_test
  import timer1_cmp_pkg::*;
;
  logic mclk, rst, io_write, io_read, global_irq_enable, vector_taken;
  logic count_step, count_down, pwm_enable, prescale_tick, counter_clear;
  logic irq_match_a, irq_match_b, irq_match_d, irq_wrap, clr;
  logic [5:0] io_addr, vector_id;
  logic [7:0] io_wdata, io_rdata, got, exp;
  logic [9:0] counter_value;
  logic [1:0] mode_select;
  logic [2:0] waveform_in, waveform_output, waveform_output_n;
  int n_fail, checks;
  // packed tables, element 0 first: channel a, then b, d and wrap
  localparam logic [2:0][5:0] CADR = {ADDR_CMP_D, ADDR_CMP_B, ADDR_CMP_A};
  localparam logic [2:0][7:0] CVAL = {8'h80, 8'h40, 8'h20};
  localparam logic [3:0][7:0] MASK = {8'h04, 8'h80, 8'h20, 8'h40};
  localparam logic [3:0][5:0] VEC = {VEC_WRAP, VEC_MATCH_D, VEC_MATCH_B,
    VEC_MATCH_A};
  timer1_compare dut (.mclk, .rst, .io_addr, .io_write, .io_read, .io_wdata,
    .io_rdata, .global_irq_enable, .vector_taken, .vector_id, .counter_value,
    .count_step, .count_down, .pwm_enable, .mode_select, .prescale_tick,
    .waveform_in, .counter_clear, .irq_match_a, .irq_match_b, .irq_match_d,
    .irq_wrap, .waveform_output, .waveform_output_n);
  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // dead time tick every other cycle, so delays show as real counts
  always @(posedge mclk) prescale_tick <= #1 ~prescale_tick;
  task automatic chk(input string what, input logic [7:0] e, s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge mclk) #1;
    {io_write, io_addr, io_wdata} = {1'b1, a, d};
    @(posedge mclk) #1;
    io_write = 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge mclk) #1;
    {io_read, io_addr} = {1'b1, a};
    @(posedge mclk) #1;
    io_read = 1'b0;
    d = io_rdata;
  endtask : rd
  // counting step; clear is caught in the cycle it stands
  task automatic step(input logic [9:0] v, output logic c);
    @(posedge mclk) #1;
    {counter_value, count_step} = {v, 1'b1};
    @(posedge mclk) #1;
    c = counter_clear;
    count_step = 1'b0;
  endtask : step
  task automatic vec(input logic [5:0] v);
    @(posedge mclk) #1;
    {vector_taken, vector_id} = {1'b1, v};
    @(posedge mclk) #1;
    vector_taken = 1'b0;
  endtask : vec
  // bounded wait for the dead time outputs; c gives the edges it took
  task automatic wait_out(input logic [2:0] t, n, output logic [7:0] c);
    c = 8'h00;
    for (int i = 0; i <= 100; i++) begin
      c = i[7:0];
      if (waveform_output === t && waveform_output_n === n) break;
      if (i == 100) begin
        n_fail++;
        $display("wrong value dead time outputs expected %h %h seen %h %h",
          t, n, waveform_output, waveform_output_n);
        wrap_up();
      end
      @(posedge mclk) #1;
    end
  endtask : wait_out
  function automatic logic [7:0] irqs();
    return {irq_match_d, irq_match_a, irq_match_b, 2'b00, irq_wrap, 2'b00};
  endfunction : irqs
  task automatic wrap_up();
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // main sequence
  initial begin
    rst = 1'b1;
    {io_write, io_read, io_addr, io_wdata, global_irq_enable} = '0;
    {vector_taken, vector_id, counter_value, count_step, count_down} = '0;
    {pwm_enable, mode_select, prescale_tick, waveform_in} = '0;
    repeat (3) @(posedge mclk);
    #1 rst = 1'b0;
    rd(ADDR_FLAGS, got); chk("flags", 8'h00, got);
    rd(ADDR_ENABLES, got); chk("enables", 8'h00, got);
    rd(ADDR_DEAD_TIME, got); chk("dead time", 8'h00, got);
    rd(6'h3F, got); chk("unmapped", 8'h00, got);
    wr(ADDR_DEAD_TIME, 8'h21);
    rd(ADDR_DEAD_TIME, got); chk("dead time", 8'h21, got);
    wr(ADDR_HIGH_BYTE, 8'h00);
    wr(ADDR_TOP, 8'h01);
    rd(ADDR_TOP, got); chk("top", 8'h03, got);
    exp = 8'h00;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_HIGH_BYTE, 8'h01);
      wr(CADR[i], CVAL[i]);
      wr(ADDR_HIGH_BYTE, 8'h00);
      rd(CADR[i], got); chk("compare", CVAL[i], got);
      rd(ADDR_HIGH_BYTE, got); chk("high byte", 8'h01, got);
      counter_value = {2'b01, CVAL[i]};
      rd(ADDR_FLAGS, got); chk("flags", exp, got);
      step({2'b01, CVAL[i]}, clr);
      exp = exp | MASK[i];
      rd(ADDR_FLAGS, got); chk("flags", exp, got);
    end
    step(10'h003, clr); chk("clear", 8'h01, {7'h00, clr});
    rd(ADDR_FLAGS, got); chk("flags", 8'hE4, got);
    chk("irqs", 8'h00, irqs());
    wr(ADDR_ENABLES, 8'hFF);
    rd(ADDR_ENABLES, got); chk("enables", 8'hE4, got);
    chk("irqs", 8'h00, irqs());
    global_irq_enable = 1'b1;
    #1 chk("irqs", 8'hE4, irqs());
    wr(ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS, got); chk("flags", 8'hE4, got);
    exp = 8'hE4;
    for (int i = 0; i < 4; i++) begin
      vec(VEC[i]);
      exp = exp & ~MASK[i];
      rd(ADDR_FLAGS, got); chk("flags", exp, got);
      chk("irqs", exp, irqs());
    end
    step(10'h120, clr);
    {pwm_enable, mode_select, count_down} = {1'b1, MODE_DUAL, 1'b1};
    step(10'h000, clr); chk("clear", 8'h00, {7'h00, clr});
    rd(ADDR_FLAGS, got); chk("flags", 8'h44, got);
    wr(ADDR_FLAGS, 8'h44);
    rd(ADDR_FLAGS, got); chk("flags", 8'h00, got);
    waveform_in = 3'b111;
    wait_out(3'b111, 3'b000, got);
    // ticks alternate, so each later change starts on a tick edge:
    // a delay of d then takes 2d + 2 edges to show
    waveform_in = 3'b000;
    wait_out(3'b000, 3'b111, got);
    chk("dead time inverted", 8'h04, got);
    waveform_in = 3'b111;
    wait_out(3'b111, 3'b000, got);
    chk("dead time true", 8'h06, got);
    // other dual-slope code: no clear at top, wrap only at zero
    {mode_select, count_down} = {MODE_PWM6_DUAL, 1'b0};
    step(10'h003, clr); chk("clear", 8'h00, {7'h00, clr});
    count_down = 1'b1;
    rd(ADDR_FLAGS, got); chk("flags", 8'h00, got);
    step(10'h000, clr);
    rd(ADDR_FLAGS, got); chk("flags", 8'h04, got);
    wr(ADDR_FLAGS, 8'h04);
    rd(ADDR_FLAGS, got); chk("flags", 8'h00, got);
    // fast pwm wraps and clears at top like normal mode
    {mode_select, count_down} = {MODE_FAST, 1'b0};
    step(10'h003, clr); chk("clear", 8'h01, {7'h00, clr});
    rd(ADDR_FLAGS, got); chk("flags", 8'h04, got);
    // reset in mid-run returns the registers to their reset values
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 rst = 1'b0;
    rd(ADDR_FLAGS, got); chk("flags", RESET_BYTE, got);
    rd(ADDR_ENABLES, got); chk("enables", RESET_BYTE, got);
    rd(ADDR_DEAD_TIME, got); chk("dead time", RESET_BYTE, got);
    rd(ADDR_TOP, got); chk("top", RESET_TOP[7:0], got);
    wrap_up();
  end
endmodule : timer1_compare_test
`default_nettype wire
